// File: rsl_pkg.sv
// Constants and types shared by the reset strap loader
package rsl_pkg;
	// Clock and timing
	localparam int unsigned RSL_CLK_PERIOD_NS = 25;
	localparam int unsigned RSL_CPU_RST_DELAY_NS = 1000000;
	localparam int unsigned RSL_CPU_RST_CYC = (RSL_CPU_RST_DELAY_NS + RSL_CLK_PERIOD_NS - 1) / RSL_CLK_PERIOD_NS;
	localparam logic [15:0] RSL_STRAP_LEAD_CYC = 16'h0006;
	localparam logic [2:0] RSL_STRAP_TAIL_CYC = 3'h4;
	localparam logic [2:0] RSL_FLOAT_TAIL_CYC = 3'h4;
	localparam int unsigned RSL_TMR_W = 16;

	// Transaction throttle
	localparam logic [3:0] RSL_IOQ_LIMIT = 4'h4;

	// Register byte offsets
	localparam logic [7:0] RSL_OFS_CFG = 8'h00;
	localparam logic [7:0] RSL_OFS_STATUS = 8'h04;
	localparam logic [7:0] RSL_OFS_CTRL = 8'h08;

	// Configuration register fields
	localparam int unsigned RSL_CFG_QD_EN_BIT = 2;
	localparam int unsigned RSL_CFG_RSVD_BIT = 13;
	localparam logic RSL_CFG_RSVD_VAL = 1'b1;

	// Status register fields
	localparam int unsigned RSL_ST_STATE_LSB = 0;
	localparam int unsigned RSL_ST_MAXQ_BIT = 4;
	localparam int unsigned RSL_ST_QSTART_BIT = 5;
	localparam int unsigned RSL_ST_BNR_BIT = 6;
	localparam int unsigned RSL_ST_CNT_LSB = 8;

	// Control register fields
	localparam int unsigned RSL_CTRL_STR_BIT = 0;
	localparam logic RSL_CTRL_STR_RST = 1'b0;

	// Bus encodings
	localparam logic [1:0] RSL_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [1:0] {
		RSL_ST_RESET,
		RSL_ST_WAIT,
		RSL_ST_HOLD,
		RSL_ST_RUN
	} rsl_state_e;
endpackage

// File: rsl_proc_model.sv
// Processor model: strap sampling at reset release and request traffic
`timescale 1ns/1ps
module rsl_proc_model (
	input wire logic clk_i,
	input wire logic processor_reset_n_i,
	input wire logic qd_wire_i,
	input wire logic qs_wire_i,
	input wire logic block_next_request_n_i,
	input wire logic go_i,
	input wire logic slow_i,
	output logic req_start_o,
	output logic req_done_o,
	output logic max_depth_o,
	output logic quick_start_o,
	output int outstanding_o,
	output int peak_o
);
	int tick = 0;
	logic s, d;
	always @(posedge processor_reset_n_i) begin
		max_depth_o <= qd_wire_i;
		quick_start_o <= !qs_wire_i;
	end
	always @(posedge clk_i) begin
		tick <= tick + 1;
		s = go_i && block_next_request_n_i && (max_depth_o || (outstanding_o == 0 && !req_start_o));
		d = outstanding_o > 0 && (!slow_i || tick % 8 == 0);
		if (!processor_reset_n_i) begin
			req_start_o <= 1'b0;
			req_done_o <= 1'b0;
			outstanding_o <= 0;
			peak_o <= 0;
		end else begin
			req_start_o <= s;
			req_done_o <= d;
			outstanding_o <= outstanding_o + s - d;
			if (outstanding_o + s > peak_o)
				peak_o <= outstanding_o + s;
		end
	end
endmodule

// File: rsl_strap_loader.sv
// Power-up strap capture, processor strap drive and queue throttle
`timescale 1ns/1ps
// Operation
// - Memory strap pins stay undriven in system reset and for at least four clocks after it ends.
// - The queue-depth enable strap is sampled during system reset into configuration bit 2, the quick-start strap into status bit 5.
// - Processor straps are driven at least six clocks before processor reset ends and released four after.
// - With maximum queue depth selected, block-next-request limits outstanding transactions to four.
// - A queue-depth enable strap of 0 makes the device drive the queue-depth strap low.
// - A queue-depth enable strap of 1 leaves the queue-depth strap undriven.
// - The reserved strap reads as 1 internally and sits in configuration bit 13.
// - The system reset input pulldown is on in cold reset and in suspend.
// - A quick-start strap of 1 makes the device drive the quick-start strap low.
// - Processor reset follows system reset and ends 1 ms after system reset ends.
module rsl_strap_loader
	import rsl_pkg::*;
#(
	parameter int unsigned CPU_RST_DELAY_CYC = RSL_CPU_RST_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// System and processor reset
	input wire logic system_bus_reset_n_i,
	output logic processor_reset_n_o,
	// Memory address strap pins
	input wire logic queue_depth_enable_strap_i,
	input wire logic reserved_strap_pin_i,
	input wire logic quick_start_strap_pin_i,
	output logic mem_strap_drive_en_o,
	// Processor address straps
	input wire logic queue_depth_addr_strap_i,
	output logic queue_depth_addr_strap_o,
	output logic queue_depth_addr_strap_oe_o,
	output logic quick_start_addr_strap_o,
	output logic quick_start_addr_strap_oe_o,
	// Processor bus request tracking
	input wire logic req_start_i,
	input wire logic req_done_i,
	output logic block_next_request_n_o,
	output logic block_next_request_n_oe_o,
	// Pulldown controls
	output logic system_bus_reset_pd_en_o,
	output logic host_clock_in_pd_en_o,
	output logic bus_clock_in_pd_en_o,
	// Selected queue depth
	output logic in_order_queue_depth_o
);
	localparam logic [RSL_TMR_W-1:0] DELAY_CYC = RSL_TMR_W'(CPU_RST_DELAY_CYC);

	function automatic logic [RSL_TMR_W-1:0] at_least(input logic [RSL_TMR_W-1:0] a, input logic [RSL_TMR_W-1:0] b);
		at_least = (a > b) ? a : b;
	endfunction

	// Pin synchronisers: meta stage feeds only the second stage
	logic [4:0] sync1_ff;
	logic [4:0] sync2_ff;
	logic [4:0] pins_raw;
	assign pins_raw = {queue_depth_addr_strap_i, quick_start_strap_pin_i, reserved_strap_pin_i,
		queue_depth_enable_strap_i, system_bus_reset_n_i};

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pins_raw;
			sync2_ff <= sync1_ff;
		end
	end

	logic sysrst_n;
	logic qd_en_pin;
	logic qs_pin;
	logic qd_addr_pin;
	assign sysrst_n = sync2_ff[0];
	assign qd_en_pin = sync2_ff[1];
	assign qs_pin = sync2_ff[3];
	assign qd_addr_pin = sync2_ff[4];

	// Sequencer
	rsl_tmr_if tmr_bus ();
	rsl_timer u_timer (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.tmr(tmr_bus.tmr)
	);

	rsl_state_e state_ff;
	rsl_state_e nxt_state;
	logic [2:0] tail_ff;
	logic [2:0] nxt_tail;
	logic [2:0] float_ff;
	logic [2:0] nxt_float;
	logic cold_ff;
	logic nxt_cold;
	logic qd_en_ff;
	logic nxt_qd_en;
	logic qs_ff;
	logic nxt_qs;
	logic maxq_ff;
	logic nxt_maxq;

	always_comb begin
		nxt_state = state_ff;
		nxt_tail = tail_ff;
		nxt_float = float_ff;
		nxt_cold = cold_ff;
		nxt_qd_en = qd_en_ff;
		nxt_qs = qs_ff;
		nxt_maxq = maxq_ff;
		tmr_bus.start = 1'b0;
		tmr_bus.load = at_least(DELAY_CYC, RSL_STRAP_LEAD_CYC);
		if (float_ff != '0) begin
			nxt_float = float_ff - 1'b1;
		end
		if (!sysrst_n) begin
			nxt_state = RSL_ST_RESET;
			nxt_float = RSL_FLOAT_TAIL_CYC;
			nxt_qd_en = qd_en_pin;
			nxt_qs = qs_pin;
		end else begin
			unique case (state_ff)
				RSL_ST_RESET: begin
					tmr_bus.start = 1'b1;
					nxt_state = RSL_ST_WAIT;
				end
				RSL_ST_WAIT: begin
					if (tmr_bus.done) begin
						nxt_state = RSL_ST_HOLD;
						nxt_tail = RSL_STRAP_TAIL_CYC;
						nxt_maxq = qd_addr_pin;
					end
				end
				RSL_ST_HOLD: begin
					nxt_tail = tail_ff - 1'b1;
					if (tail_ff == 3'h1) begin
						nxt_state = RSL_ST_RUN;
						nxt_cold = 1'b0;
					end
				end
				RSL_ST_RUN: begin
					nxt_state = RSL_ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= RSL_ST_RESET;
			tail_ff <= '0;
			float_ff <= RSL_FLOAT_TAIL_CYC;
			cold_ff <= 1'b1;
			qd_en_ff <= 1'b1;
			qs_ff <= 1'b1;
			maxq_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			tail_ff <= nxt_tail;
			float_ff <= nxt_float;
			cold_ff <= nxt_cold;
			qd_en_ff <= nxt_qd_en;
			qs_ff <= nxt_qs;
			maxq_ff <= nxt_maxq;
		end
	end

	// Pin drive; straps driven from system reset release until four clocks after processor reset release
	logic strap_win;
	assign strap_win = sysrst_n && (state_ff == RSL_ST_WAIT || state_ff == RSL_ST_HOLD);

	logic proc_rst_n_ff;
	logic nxt_proc_rst_n;
	logic qd_oe_ff;
	logic nxt_qd_oe;
	logic qs_oe_ff;
	logic nxt_qs_oe;
	logic mem_en_ff;
	logic nxt_mem_en;

	always_comb begin
		nxt_proc_rst_n = sysrst_n && (nxt_state == RSL_ST_HOLD || nxt_state == RSL_ST_RUN);
		nxt_qd_oe = strap_win && !qd_en_ff && nxt_state != RSL_ST_RUN && nxt_state != RSL_ST_RESET;
		nxt_qs_oe = strap_win && qs_ff && nxt_state != RSL_ST_RUN && nxt_state != RSL_ST_RESET;
		nxt_mem_en = sysrst_n && nxt_float == '0 && state_ff != RSL_ST_RESET;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			proc_rst_n_ff <= 1'b0;
			qd_oe_ff <= 1'b0;
			qs_oe_ff <= 1'b0;
			mem_en_ff <= 1'b0;
		end else begin
			proc_rst_n_ff <= nxt_proc_rst_n;
			qd_oe_ff <= nxt_qd_oe;
			qs_oe_ff <= nxt_qs_oe;
			mem_en_ff <= nxt_mem_en;
		end
	end

	assign processor_reset_n_o = proc_rst_n_ff;
	assign queue_depth_addr_strap_o = 1'b0;
	assign queue_depth_addr_strap_oe_o = qd_oe_ff;
	assign quick_start_addr_strap_o = 1'b0;
	assign quick_start_addr_strap_oe_o = qs_oe_ff;
	assign mem_strap_drive_en_o = mem_en_ff;
	assign in_order_queue_depth_o = maxq_ff;

	// Outstanding transaction count and throttle
	logic [3:0] cnt_ff;
	logic [3:0] nxt_cnt;
	logic bnr_ff;
	logic nxt_bnr;

	always_comb begin
		nxt_cnt = cnt_ff;
		if (!proc_rst_n_ff) begin
			nxt_cnt = '0;
		end else if (req_start_i && !req_done_i) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (!req_start_i && req_done_i && cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		// Registered one ahead so a request in the same cycle is still covered
		nxt_bnr = maxq_ff && proc_rst_n_ff && nxt_cnt >= RSL_IOQ_LIMIT - 4'h1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= '0;
			bnr_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			bnr_ff <= nxt_bnr;
		end
	end

	assign block_next_request_n_o = 1'b0;
	assign block_next_request_n_oe_o = bnr_ff;

	// Register file
	logic str_ff;
	logic nxt_str;
	logic wr_pend_ff;
	logic nxt_wr_pend;
	logic [7:0] wr_addr_ff;
	logic [7:0] nxt_wr_addr;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic [31:0] cfg_val;
	logic [31:0] status_val;
	logic addr_phase;

	always_comb begin
		cfg_val = '0;
		cfg_val[RSL_CFG_QD_EN_BIT] = qd_en_ff;
		cfg_val[RSL_CFG_RSVD_BIT] = RSL_CFG_RSVD_VAL;
		status_val = '0;
		status_val[RSL_ST_STATE_LSB +: 2] = state_ff;
		status_val[RSL_ST_MAXQ_BIT] = maxq_ff;
		status_val[RSL_ST_QSTART_BIT] = qs_ff;
		status_val[RSL_ST_BNR_BIT] = bnr_ff;
		status_val[RSL_ST_CNT_LSB +: 4] = cnt_ff;
	end

	assign addr_phase = hsel_i && hready_i && htrans_i[1];

	always_comb begin
		nxt_str = str_ff;
		nxt_wr_pend = addr_phase && hwrite_i;
		nxt_wr_addr = addr_phase ? haddr_i : wr_addr_ff;
		nxt_rdata = rdata_ff;
		if (wr_pend_ff && wr_addr_ff == RSL_OFS_CTRL) begin
			nxt_str = hwdata_i[RSL_CTRL_STR_BIT];
		end
		if (addr_phase && !hwrite_i) begin
			unique case (haddr_i)
				RSL_OFS_CFG: nxt_rdata = cfg_val;
				RSL_OFS_STATUS: nxt_rdata = status_val;
				RSL_OFS_CTRL: nxt_rdata = {31'h0, str_ff};
				default: nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			str_ff <= RSL_CTRL_STR_RST;
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			rdata_ff <= '0;
		end else begin
			str_ff <= nxt_str;
			wr_pend_ff <= nxt_wr_pend;
			wr_addr_ff <= nxt_wr_addr;
			rdata_ff <= nxt_rdata;
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign hrdata_o = rdata_ff;

	// Pulldowns: cold reset lasts until four clocks after the first processor reset release
	logic pd_ff;
	logic nxt_pd;
	always_comb begin
		nxt_pd = nxt_cold || nxt_str;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pd_ff <= 1'b1;
		end else begin
			pd_ff <= nxt_pd;
		end
	end

	assign system_bus_reset_pd_en_o = pd_ff;
	assign host_clock_in_pd_en_o = pd_ff;
	assign bus_clock_in_pd_en_o = pd_ff;
endmodule

// File: rsl_strap_loader_checker.sv
// Port assertions for the reset strap loader
`timescale 1ns/1ps
module rsl_strap_loader_checker (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic system_bus_reset_n_i,
	input wire logic processor_reset_n_o,
	input wire logic mem_strap_drive_en_o,
	input wire logic queue_depth_addr_strap_oe_o,
	input wire logic quick_start_addr_strap_oe_o,
	input wire logic req_start_i,
	input wire logic req_done_i,
	input wire logic block_next_request_n_oe_o,
	input wire logic system_bus_reset_pd_en_o,
	input wire logic host_clock_in_pd_en_o,
	input wire logic bus_clock_in_pd_en_o,
	input wire logic in_order_queue_depth_o
);
	logic [3:0] out_ff;
	// Outstanding requests, seen from the ports only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			out_ff <= 4'h0;
		else if (!processor_reset_n_o)
			out_ff <= 4'h0;
		else
			out_ff <= out_ff + {3'h0, req_start_i} - {3'h0, req_done_i};
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_proc_rst_follow: assert property (!system_bus_reset_n_i |-> ##[1:4] !processor_reset_n_o)
		else $error("processor reset not following system reset");
	a_mem_float: assert property ($rose(system_bus_reset_n_i) |-> !mem_strap_drive_en_o [*6])
		else $error("memory straps driven too early");
	a_strap_lead: assert property ($rose(processor_reset_n_o) && quick_start_addr_strap_oe_o
		|-> $past(quick_start_addr_strap_oe_o, 6))
		else $error("strap drive lead too short");
	a_strap_tail: assert property ($rose(processor_reset_n_o) && quick_start_addr_strap_oe_o
		|-> quick_start_addr_strap_oe_o [*3] ##[1:2] !quick_start_addr_strap_oe_o)
		else $error("strap drive tail wrong");
	a_bnr_max_only: assert property (block_next_request_n_oe_o |-> in_order_queue_depth_o)
		else $error("block next request without max depth");
	a_bnr_throttle: assert property (processor_reset_n_o && in_order_queue_depth_o && out_ff >= 4'h3
		|-> ##[0:1] block_next_request_n_oe_o)
		else $error("block next request late");
	a_queue_limit: assert property (out_ff <= 4'h4)
		else $error("more than four outstanding");
	a_pd_same: assert property (host_clock_in_pd_en_o == system_bus_reset_pd_en_o
		&& bus_clock_in_pd_en_o == system_bus_reset_pd_en_o)
		else $error("pulldown enables disagree");
	a_bus_okay: assert property (hreadyout_o && !hresp_o)
		else $error("bus response not ready okay");
endmodule
bind rsl_strap_loader rsl_strap_loader_checker u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .system_bus_reset_n_i(system_bus_reset_n_i),
	.processor_reset_n_o(processor_reset_n_o), .mem_strap_drive_en_o(mem_strap_drive_en_o),
	.queue_depth_addr_strap_oe_o(queue_depth_addr_strap_oe_o),
	.quick_start_addr_strap_oe_o(quick_start_addr_strap_oe_o), .req_start_i(req_start_i),
	.req_done_i(req_done_i), .block_next_request_n_oe_o(block_next_request_n_oe_o),
	.system_bus_reset_pd_en_o(system_bus_reset_pd_en_o), .host_clock_in_pd_en_o(host_clock_in_pd_en_o),
	.bus_clock_in_pd_en_o(bus_clock_in_pd_en_o), .in_order_queue_depth_o(in_order_queue_depth_o));

// File: rsl_strap_loader_tb_top.sv
// Self-checking bench for the reset strap loader
`timescale 1ns/1ps
module rsl_strap_loader_tb_top;
	import rsl_pkg::*;
	localparam int DLY = 20;
	logic clk_i = 0, arst_n_i = 0, hwrite = 0, sys_n = 0, qd_en = 1, rsv = 1, qs = 1;
	logic board_low = 0, go = 0, slow = 0;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [31:0] hwdata = 0, rd;
	logic hready, hresp, prst_n, mem_en, qd_o, qd_oe, qs_o, qs_oe, bnr_o, bnr_oe, pd_s, pd_h, pd_b, in_order_queue_depth;
	logic [31:0] hrdata;
	logic req_s, req_d, m_max, m_qs;
	int outst, peak, n_mismatch = 0, comparisons = 0, cyc = 0, seed = 10117;
	wire qd_wire = qd_oe ? qd_o : !board_low;
	wire qs_wire = qs_oe ? qs_o : 1'b1;
	always #12.5 clk_i = ~clk_i;
	rsl_strap_loader #(.CPU_RST_DELAY_CYC(DLY)) uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(1'b1),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
		.system_bus_reset_n_i(sys_n), .processor_reset_n_o(prst_n), .queue_depth_enable_strap_i(qd_en),
		.reserved_strap_pin_i(rsv), .quick_start_strap_pin_i(qs), .mem_strap_drive_en_o(mem_en),
		.queue_depth_addr_strap_i(qd_wire), .queue_depth_addr_strap_o(qd_o),
		.queue_depth_addr_strap_oe_o(qd_oe), .quick_start_addr_strap_o(qs_o),
		.quick_start_addr_strap_oe_o(qs_oe), .req_start_i(req_s), .req_done_i(req_d),
		.block_next_request_n_o(bnr_o), .block_next_request_n_oe_o(bnr_oe),
		.system_bus_reset_pd_en_o(pd_s), .host_clock_in_pd_en_o(pd_h), .bus_clock_in_pd_en_o(pd_b),
		.in_order_queue_depth_o(in_order_queue_depth));
	rsl_proc_model u_cpu (.clk_i(clk_i), .processor_reset_n_i(prst_n), .qd_wire_i(qd_wire),
		.qs_wire_i(qs_wire), .block_next_request_n_i(bnr_oe ? bnr_o : 1'b1), .go_i(go), .slow_i(slow),
		.req_start_o(req_s), .req_done_o(req_d), .max_depth_o(m_max), .quick_start_o(m_qs),
		.outstanding_o(outst), .peak_o(peak));
	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		htrans <= RSL_HTRANS_NONSEQ;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk_i); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_i); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task pd(input logic e);
		check({pd_s, pd_h, pd_b}, {3{e}}, "pulldowns");
	endtask
	task results;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			results;
		end
	end
	initial begin
		int n;
		logic mx;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1;
		@(posedge clk_i);
		pd(1);
		bus(0, RSL_OFS_CTRL, 0);
		check(rd, 0, "ctrl reset");
		for (int i = 0; i < 8; i++) begin
			sys_n <= 0;
			qd_en <= i[0];
			qs <= i[1];
			board_low <= i[2];
			rsv <= 1'($random(seed));
			repeat (6) @(posedge clk_i);
			sys_n <= 1;
			n = 0;
			while (prst_n !== 1'b1 && n < 200) begin
				@(posedge clk_i);
				n++;
			end
			check(n >= DLY && n <= DLY + 6, 1, "cpu reset delay");
			// Pin levels now follow memory traffic, not straps
			qd_en <= !i[0];
			qs <= !i[1];
			rsv <= !rsv;
			repeat (8) @(posedge clk_i);
			board_low <= 0;
			mx = i[0] && !i[2];
			check(mem_en, 1, "mem drive");
			bus(0, RSL_OFS_CFG, 0);
			check(rd, {18'h0, RSL_CFG_RSVD_VAL, 10'h0, i[0], 2'h0}, "cfg");
			bus(0, RSL_OFS_STATUS, 0);
			check(rd[5:4], {i[1], mx}, "status");
			check({in_order_queue_depth, m_max, m_qs}, {mx, mx, i[1]}, "cpu straps");
			if (i == 0) begin
				pd(0);
				bus(1, RSL_OFS_CTRL, 1);
				bus(0, RSL_OFS_CTRL, 0);
				check(rd, 1, "ctrl");
				pd(1);
				bus(1, 8'hfc, 32'hffffffff);
				bus(0, 8'hfc, 0);
				check(rd, 0, "unmapped");
				bus(1, RSL_OFS_CTRL, 0);
				// Pulldowns update on the write's data edge; look once they have settled
				@(posedge clk_i);
				pd(0);
			end
			go <= 1;
			repeat (30) begin
				slow <= 1'($random(seed));
				@(posedge clk_i);
			end
			slow <= 1;
			repeat (40) @(posedge clk_i);
			go <= 0;
			n = 0;
			while (outst != 0 && n < 400) begin
				@(posedge clk_i);
				n++;
			end
			check(peak, mx ? 4 : 1, "queue depth");
			// Short pulse after the release has completed, which restarts the release sequence
			sys_n <= 0;
			repeat (5) @(posedge clk_i);
			sys_n <= 1;
			repeat (10) @(posedge clk_i);
			check(prst_n, 0, "aborted release");
		end
		results;
	end
endmodule

// File: rsl_timer.sv
// Down counter that flags expiry of a loaded interval
`timescale 1ns/1ps
module rsl_timer
	import rsl_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Control
	rsl_tmr_if.tmr tmr
);
	logic [RSL_TMR_W-1:0] cnt_ff;
	logic [RSL_TMR_W-1:0] nxt_cnt;
	logic run_ff;
	logic nxt_run;

	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_run = run_ff;
		if (tmr.start) begin
			nxt_cnt = tmr.load;
			nxt_run = 1'b1;
		end else if (run_ff && cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end else begin
			nxt_run = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			run_ff <= nxt_run;
		end
	end

	assign tmr.done = run_ff && cnt_ff == '0;
endmodule

// File: rsl_tmr_if.sv
// Start and done signals between sequencer and delay timer
`timescale 1ns/1ps
interface rsl_tmr_if;
	import rsl_pkg::*;
	logic start;
	logic [RSL_TMR_W-1:0] load;
	logic done;
	modport ctl (output start, output load, input done);
	modport tmr (input start, input load, output done);
endinterface
